// ### src/cfs_pkg.sv
// Constants, types and carriers for the cube face select block
package cfs_pkg;
    // ------------------------------------------------------------
    // Number formats
    // ------------------------------------------------------------
    localparam int COORD_W   = 16;           // Signed Q2.13 direction components
    localparam int FRAC_W    = 13;
    localparam int ST_W      = 16;           // Unsigned face coordinate, 1.0 at ONE_FX
    localparam int IDX_W     = 8;            // Signed texel index, covers -1 .. FACE_N
    localparam int SIZE_LOG2 = 6;            // Face edge of 64 texels
    localparam int FACE_N    = 64;
    localparam int SHIFT_T   = FRAC_W - SIZE_LOG2;
    localparam int HALF_TEXEL = 64;          // Half a texel in Q.13 for a 64 texel face
    localparam int TAP_N     = 4;
    localparam int CHAN_N    = 4;
    localparam int CHAN_W    = 8;
    localparam int TEXEL_W   = CHAN_N * CHAN_W;
    localparam int CORNER_N  = 3;
    localparam int DIV_W     = 32;
    localparam logic signed [COORD_W-1:0] ONE_FX   = 16'sh2000;
    localparam logic        [ST_W-1:0]    ST_ONE   = 16'h2000;
    localparam logic signed [IDX_W-1:0]   IDX_LAST = 8'sh3F;
    localparam logic signed [IDX_W-1:0]   IDX_END  = 8'sh40;
    localparam logic signed [IDX_W-1:0]   IDX_ZERO = 8'sh00;
    localparam logic [CHAN_W+1:0]         MEAN_DIV = 10'h003;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        face_pos_x = 6'h01,
        face_neg_x = 6'h02,
        face_pos_y = 6'h04,
        face_neg_y = 6'h08,
        face_pos_z = 6'h10,
        face_neg_z = 6'h20
    } cfs_face_type;

    typedef enum logic [2:0] {
        wrap_texture       = 3'h1,   // Downstream applies the configured wrap modes
        edge_texel_clamp   = 3'h2,
        border_texel_clamp = 3'h4
    } cfs_wrap_type;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic signed [COORD_W-1:0] x;
        logic signed [COORD_W-1:0] y;
        logic signed [COORD_W-1:0] z;
    } cfs_dir_type;

    typedef struct packed {
        cfs_face_type     face;
        logic [ST_W-1:0]  s;
        logic [ST_W-1:0]  t;
    } cfs_proj_type;

    typedef struct packed {
        logic                    valid;
        cfs_face_type            face;
        logic signed [IDX_W-1:0] i;
        logic signed [IDX_W-1:0] j;
    } cfs_tap_type;
endpackage

// ### src/cfs_cube_select.sv
// Cube face selection, face coordinates, seamless tap remap and corner texel synthesis
`timescale 1ns/1ps
// Notes on behaviour
// - Pick face of largest magnitude component, signed.
// - Fourth coordinate q plays no part.
// - Ties broken deterministically from vector only.
// - X and Y faces use fixed sc/tc table.
// - Z faces use fixed sc/tc table.
// - s,t equal half of sc/|ma| plus one.
// - One seamless enable bit, cleared at reset.
// - Seamless off: selected face, normal wrapping.
// - Seamless on: configured wrap modes are ignored.
// - Seamless nearest clamps to face edge texels.
// - Seamless linear uses border clamp, then neighbours.
// - One-axis border tap comes from neighbouring face.
// - Corner texel is mean of three others.
// - Equal three corner texels give that value.
module cfs_cube_select (
    // Clock and reset
    input  wire  logic                                    ref_clk,
    input  wire  logic                                    sys_rst,
    // Seamless enable control
    input  wire  logic                                    seamless_set,
    input  wire  logic                                    seamless_clr,
    output logic                                          seamless_en,
    // Fragment side
    input  wire  logic                                    in_valid,
    input  wire  cfs_pkg::cfs_dir_type                    in_dir,
    input  wire  logic                                    in_linear,
    // Texel fetch side
    output logic                                          out_valid,
    output cfs_pkg::cfs_face_type                         out_face,
    output logic [cfs_pkg::ST_W-1:0]                      out_s,
    output logic [cfs_pkg::ST_W-1:0]                      out_t,
    output cfs_pkg::cfs_wrap_type                         out_wrap,
    output cfs_pkg::cfs_tap_type [cfs_pkg::TAP_N-1:0]     out_taps,
    output logic                                          out_corner,
    // Corner texel synthesis
    input  wire  logic                                    corner_valid,
    input  wire  logic [cfs_pkg::CORNER_N-1:0][cfs_pkg::TEXEL_W-1:0] corner_in,
    output logic                                          corner_out_valid,
    output logic [cfs_pkg::TEXEL_W-1:0]                   corner_out
);
    import cfs_pkg::*;

    // ------------------------------------------------------------
    // Geometry helpers
    // ------------------------------------------------------------
    function automatic logic [COORD_W:0] mag(input logic signed [COORD_W-1:0] v);
        logic signed [COORD_W:0] w;
        w = {v[COORD_W-1], v};
        mag = w[COORD_W] ? COORD_W'(0) - w : w;
    endfunction

    // Only s, t and r form the vector; q never enters here
    function automatic cfs_face_type pick_face(input cfs_dir_type d);
        logic [COORD_W:0] ax, ay, az;
        ax = mag(d.x);
        ay = mag(d.y);
        az = mag(d.z);
        // Ties go x over y over z, purely from the vector
        if (ax >= ay && ax >= az) begin
            pick_face = d.x[COORD_W-1] ? face_neg_x : face_pos_x;
        end else if (ay >= az) begin
            pick_face = d.y[COORD_W-1] ? face_neg_y : face_pos_y;
        end else begin
            pick_face = d.z[COORD_W-1] ? face_neg_z : face_pos_z;
        end
    endfunction

    function automatic logic [ST_W-1:0] to_st(input logic signed [COORD_W-1:0] c,
                                              input logic signed [COORD_W-1:0] ma);
        logic signed [DIV_W-1:0] num, den, q;
        num = DIV_W'(c) <<< FRAC_W;
        den = ma[COORD_W-1] ? -DIV_W'(ma) : DIV_W'(ma);
        q   = (den == 0) ? 0 : num / den;
        q   = (q + DIV_W'(ONE_FX)) >>> 1;
        to_st = ST_W'((q < 0) ? DIV_W'(0) : ((q > DIV_W'(ONE_FX)) ? DIV_W'(ONE_FX) : q));
    endfunction

    function automatic cfs_proj_type project(input cfs_dir_type d);
        logic signed [COORD_W-1:0] sc, tc, ma;
        project.face = pick_face(d);
        case (project.face)
            face_pos_x: begin sc = -d.z; tc = -d.y; ma = d.x; end
            face_neg_x: begin sc =  d.z; tc = -d.y; ma = d.x; end
            face_pos_y: begin sc =  d.x; tc =  d.z; ma = d.y; end
            face_neg_y: begin sc =  d.x; tc = -d.z; ma = d.y; end
            face_pos_z: begin sc =  d.x; tc = -d.y; ma = d.z; end
            face_neg_z: begin sc = -d.x; tc = -d.y; ma = d.z; end
            default:    begin sc =  d.x; tc = -d.y; ma = d.z; end
        endcase
        project.s = to_st(sc, ma);
        project.t = to_st(tc, ma);
    endfunction

    // Inverse of the face table with |ma| = 1
    function automatic cfs_dir_type unproject(input cfs_face_type f,
                                              input logic signed [COORD_W-1:0] sc,
                                              input logic signed [COORD_W-1:0] tc);
        case (f)
            face_pos_x: unproject = '{x:  ONE_FX, y: -tc, z: -sc};
            face_neg_x: unproject = '{x: -ONE_FX, y: -tc, z:  sc};
            face_pos_y: unproject = '{x:  sc, y:  ONE_FX, z:  tc};
            face_neg_y: unproject = '{x:  sc, y: -ONE_FX, z: -tc};
            face_pos_z: unproject = '{x:  sc, y: -tc, z:  ONE_FX};
            default:    unproject = '{x: -sc, y: -tc, z: -ONE_FX};
        endcase
    endfunction

    // Texel centre in face units; index -1 or FACE_N lands just past the edge
    function automatic logic signed [COORD_W-1:0] centre(input logic signed [IDX_W-1:0] i);
        centre = COORD_W'((DIV_W'(i) * 2 + 1) <<< SHIFT_T) - ONE_FX;
    endfunction
    function automatic logic signed [IDX_W-1:0] near_idx(input logic [ST_W-1:0] s);
        logic [ST_W-1:0] v;
        v = s >> SHIFT_T;
        near_idx = (v > ST_W'(IDX_LAST)) ? IDX_LAST : IDX_W'(v);
    endfunction
    function automatic logic signed [IDX_W-1:0] low_idx(input logic [ST_W-1:0] s);
        logic signed [DIV_W-1:0] u;
        u = $signed({16'h0000, s}) - HALF_TEXEL;
        low_idx = IDX_W'(u >>> SHIFT_T);
    endfunction

    // ------------------------------------------------------------
    // Seamless enable state
    // ------------------------------------------------------------
    logic seamless_r;
    logic seamless_nxt;

    always_comb begin
        seamless_nxt = seamless_set ? 1'b1 : (seamless_clr ? 1'b0 : seamless_r);
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            seamless_r <= 1'b0;
        end else begin
            seamless_r <= seamless_nxt;
        end
    end

    assign seamless_en = seamless_r;
    // ------------------------------------------------------------
    // Face selection and taps
    // ------------------------------------------------------------
    cfs_proj_type            proj;
    logic signed [IDX_W-1:0] iu0;
    logic signed [IDX_W-1:0] iv0;
    cfs_tap_type [TAP_N-1:0] tap_nxt;
    assign proj = project(in_dir);
    assign iu0  = in_linear ? low_idx(proj.s) : near_idx(proj.s);
    assign iv0  = in_linear ? low_idx(proj.t) : near_idx(proj.t);
    // Remap is done per tap in parallel: area traded for a single cycle of latency
    for (genvar g = 0; g < TAP_N; g++) begin : g_tap
        logic signed [IDX_W-1:0] iu, iv;
        logic                    in_u, in_v;
        cfs_proj_type            nb;
        assign iu   = iu0 + IDX_W'(g % 2);
        assign iv   = iv0 + IDX_W'(g / 2);
        assign in_u = (iu >= IDX_ZERO) && (iu < IDX_END);
        assign in_v = (iv >= IDX_ZERO) && (iv < IDX_END);
        assign nb   = project(unproject(proj.face, centre(iu), centre(iv)));
        always_comb begin
            tap_nxt[g] = '{valid: 1'b1, face: proj.face, i: iu, j: iv};
            if (!in_linear) begin
                tap_nxt[g].valid = (g == 0);
            end else if (seamless_r && !in_u && !in_v) begin
                tap_nxt[g].valid = 1'b0;
            end else if (seamless_r && (!in_u || !in_v)) begin
                tap_nxt[g] = '{valid: 1'b1, face: nb.face, i: near_idx(nb.s), j: near_idx(nb.t)};
            end
        end
    end

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    logic                    out_valid_r;
    logic                    out_valid_nxt;
    cfs_proj_type            proj_r;
    cfs_proj_type            proj_nxt;
    cfs_wrap_type            wrap_r;
    cfs_wrap_type            wrap_nxt;
    cfs_tap_type [TAP_N-1:0] taps_r;
    cfs_tap_type [TAP_N-1:0] taps_nxt;
    logic                    corner_r;
    logic                    corner_nxt;

    always_comb begin
        out_valid_nxt = in_valid;
        proj_nxt      = in_valid ? proj : proj_r;
        taps_nxt      = in_valid ? tap_nxt : taps_r;
        wrap_nxt      = wrap_r;
        corner_nxt    = corner_r;
        if (in_valid) begin
            corner_nxt = 1'b0;
            if (!seamless_r) begin
                wrap_nxt = wrap_texture;
            end else if (!in_linear) begin
                wrap_nxt = edge_texel_clamp;
            end else begin
                wrap_nxt   = border_texel_clamp;
                corner_nxt = ~&{tap_nxt[0].valid, tap_nxt[1].valid, tap_nxt[2].valid, tap_nxt[3].valid};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            out_valid_r <= 1'b0;
            proj_r      <= '{face: face_pos_x, s: '0, t: '0};
            wrap_r      <= wrap_texture;
            taps_r      <= '0;
            corner_r    <= 1'b0;
        end else begin
            out_valid_r <= out_valid_nxt;
            proj_r      <= proj_nxt;
            wrap_r      <= wrap_nxt;
            taps_r      <= taps_nxt;
            corner_r    <= corner_nxt;
        end
    end

    assign out_valid  = out_valid_r;
    assign out_face   = proj_r.face;
    assign out_s      = proj_r.s;
    assign out_t      = proj_r.t;
    assign out_wrap   = wrap_r;
    assign out_taps   = taps_r;
    assign out_corner = corner_r;

    // ------------------------------------------------------------
    // Corner texel synthesis
    // ------------------------------------------------------------
    logic                 cvalid_r, cvalid_nxt;
    logic [TEXEL_W-1:0]   cmean_r, cmean_nxt;
    // Exact division by three keeps three equal inputs unchanged
    for (genvar c = 0; c < CHAN_N; c++) begin : g_chan
        logic [CHAN_W+1:0] sum;
        assign sum = 10'(corner_in[0][c*CHAN_W +: CHAN_W]) + 10'(corner_in[1][c*CHAN_W +: CHAN_W])
                   + 10'(corner_in[2][c*CHAN_W +: CHAN_W]);
        always_comb begin
            cmean_nxt[c*CHAN_W +: CHAN_W] = corner_valid ? CHAN_W'(sum / MEAN_DIV)
                                                         : cmean_r[c*CHAN_W +: CHAN_W];
        end
    end

    assign cvalid_nxt = corner_valid;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cvalid_r <= 1'b0;
            cmean_r  <= '0;
        end else begin
            cvalid_r <= cvalid_nxt;
            cmean_r  <= cmean_nxt;
        end
    end

    assign corner_out_valid = cvalid_r;
    assign corner_out       = cmean_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_pos_x_major;
        in_valid && !in_dir.x[COORD_W-1] && mag(in_dir.x) > mag(in_dir.y) && mag(in_dir.x) > mag(in_dir.z);
    endsequence

    a_reset_disabled: assert property (@(posedge ref_clk) sys_rst |=> !seamless_en)
        else $error("seamless enable not cleared by reset");
    a_set_enables: assert property (@(posedge ref_clk) disable iff (sys_rst)
        seamless_set |=> seamless_en)
        else $error("seamless set ignored");
    a_major_face: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_pos_x_major |=> out_valid && out_face == face_pos_x)
        else $error("positive x major axis not selected");
    a_st_range: assert property (@(posedge ref_clk) disable iff (sys_rst)
        out_valid |-> out_s <= ST_ONE && out_t <= ST_ONE)
        else $error("face coordinate out of range");
    a_plain_wrap: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_valid && !seamless_en |=> out_wrap == wrap_texture)
        else $error("wrap overridden with seamless off");
    a_nearest_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_valid && seamless_en && !in_linear |=> out_wrap == edge_texel_clamp
        && out_taps[0].i >= IDX_ZERO && out_taps[0].i < IDX_END)
        else $error("nearest tap not clamped to edge");
    a_linear_taps: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_valid && seamless_en && in_linear |=> out_wrap == border_texel_clamp
        && (!out_taps[1].valid || (out_taps[1].i >= IDX_ZERO && out_taps[1].i < IDX_END)))
        else $error("seamless linear tap left in border");
    a_corner_equal: assert property (@(posedge ref_clk) disable iff (sys_rst)
        corner_valid && corner_in[0] == corner_in[1] && corner_in[1] == corner_in[2]
        |=> corner_out_valid && corner_out == $past(corner_in[0]))
        else $error("corner texel differs from common value");
endmodule // cfs_cube_select

// ### testbench/cfs_far_model.sv
// Far side model: texel pipeline that answers cube corners through the corner port
`timescale 1ns/1ps
module cfs_far_model (
    // Clock
    input  wire logic                                                ref_clk,
    // Observed fetch side
    input  wire logic                                                out_valid,
    input  wire logic                                                out_corner,
    input  wire cfs_pkg::cfs_tap_type [cfs_pkg::TAP_N-1:0]           out_taps,
    // Requests commanded by the bench
    input  wire logic                                                ext_req,
    input  wire logic [cfs_pkg::CORNER_N-1:0][cfs_pkg::TEXEL_W-1:0]  ext_texels,
    // Corner port
    output logic                                                     corner_valid,
    output logic [cfs_pkg::CORNER_N-1:0][cfs_pkg::TEXEL_W-1:0]       corner_in
);
    import cfs_pkg::*;
    logic                              req_q;
    logic                              cor_q;
    logic [CORNER_N-1:0][TEXEL_W-1:0]  ext_q;
    logic [CORNER_N-1:0][TEXEL_W-1:0]  fetched;
    logic [CORNER_N-1:0][TEXEL_W-1:0]  fetch_q;
    int                                k;
    initial begin
        corner_valid = 1'b0;
        corner_in    = '0;
    end
    // Texel value is a hash of its address, so distinct corners carry distinct data
    always_comb begin
        fetched = '0;
        k       = 0;
        for (int g = 0; g < TAP_N; g++) begin
            if (out_taps[g].valid && k < CORNER_N) begin
                fetched[k] = {2'h2, out_taps[g].face, out_taps[g].i, out_taps[g].j, 8'h5A};
                k++;
            end
        end
    end
    always @(posedge ref_clk) begin
        req_q   = ext_req;
        ext_q   = ext_texels;
        cor_q   = out_valid && out_corner;
        fetch_q = fetched;
        #1;
        corner_valid = req_q || cor_q;
        if (req_q)
            corner_in = ext_q;
        else if (cor_q)
            corner_in = fetch_q;
        else
            corner_in = ~corner_in;   // Idle data never holds its last value
    end
endmodule // cfs_far_model

// ### testbench/tb.sv
// Self-checking bench for the cube face select block
`timescale 1ns/1ps
module tb;
    import cfs_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                              ref_clk, sys_rst, seamless_set, seamless_clr, seamless_en;
    logic                              in_valid, in_linear, out_valid, out_corner, ext_req;
    logic                              corner_valid, corner_out_valid, pend, seam;
    cfs_dir_type                       in_dir;
    cfs_face_type                      out_face;
    logic [ST_W-1:0]                   out_s, out_t;
    cfs_wrap_type                      out_wrap;
    cfs_tap_type [TAP_N-1:0]           out_taps;
    logic [CORNER_N-1:0][TEXEL_W-1:0]  corner_in, ext_texels;
    logic [TEXEL_W-1:0]                corner_out, pend_exp, w;
    logic [31:0]                       seed;
    int                                failures, n_checks;
    // Major components of 1.0 (one entry is the zero vector) and even others keep every expected s and t exact
    localparam logic [47:0] FIX [9] = '{48'h2000_0800_F000, 48'hE000_1000_0400, 48'h0400_2000_F800,
        48'h0C00_E000_0600, 48'h0200_FA00_2000, 48'hF800_0400_E000, 48'h2000_2000_2000,
        48'h0000_0000_0000, 48'h1000_E000_2000};

    cfs_cube_select i_dut (.ref_clk, .sys_rst, .seamless_set, .seamless_clr, .seamless_en, .in_valid,
        .in_dir, .in_linear, .out_valid, .out_face, .out_s, .out_t, .out_wrap, .out_taps, .out_corner,
        .corner_valid, .corner_in, .corner_out_valid, .corner_out);
    cfs_far_model i_far (.ref_clk, .out_valid, .out_corner, .out_taps, .ext_req, .ext_texels,
        .corner_valid, .corner_in);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic cfs_dir_type rnd_dir();
        logic [31:0]               r;
        logic signed [COORD_W-1:0] a, b, m;
        r = nxt();
        a = 16'(int'(r[16:4]) * 2 - 8192);
        b = 16'(int'(r[29:17]) * 2 - 8192);
        m = r[2] ? 16'shE000 : 16'sh2000;
        case (r[1:0])
            2'h0: return '{m, a, b};
            2'h1: return '{a, m, b};
            default: return '{a, b, m};
        endcase
    endfunction

    function automatic cfs_proj_type exp_proj(cfs_dir_type d);
        int           x, y, z, ax, ay, az, sc, tc, ma;
        cfs_proj_type p;
        x  = d.x;
        y  = d.y;
        z  = d.z;
        ax = x < 0 ? -x : x;
        ay = y < 0 ? -y : y;
        az = z < 0 ? -z : z;
        if (ax >= ay && ax >= az) begin
            ma     = x;
            sc     = x >= 0 ? -z : z;
            tc     = -y;
            p.face = x >= 0 ? face_pos_x : face_neg_x;
        end else if (ay >= az) begin
            ma     = y;
            sc     = x;
            tc     = y >= 0 ? z : -z;
            p.face = y >= 0 ? face_pos_y : face_neg_y;
        end else begin
            ma     = z;
            sc     = z >= 0 ? x : -x;
            tc     = -y;
            p.face = z >= 0 ? face_pos_z : face_neg_z;
        end
        if (ma == 0) begin
            sc = 0;
            ma = 1;
            tc = 0;
        end
        ma  = ma < 0 ? -ma : ma;
        p.s = 16'(4096 + sc * 4096 / ma);
        p.t = 16'(4096 + tc * 4096 / ma);
        return p;
    endfunction

    function automatic logic [TEXEL_W-1:0] mean3(logic [CORNER_N-1:0][TEXEL_W-1:0] v);
        logic [TEXEL_W-1:0] m;
        for (int c = 0; c < CHAN_N; c++)
            m[c*8 +: 8] = 8'((10'(v[0][c*8 +: 8]) + 10'(v[1][c*8 +: 8]) + 10'(v[2][c*8 +: 8])) / 10'h003);
        return m;
    endfunction

    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic set_seam(input logic s_set, input logic s_clr, input logic v);
        @(posedge ref_clk);
        #1;
        seamless_set = s_set;
        seamless_clr = s_clr;
        @(posedge ref_clk);
        #1;
        seamless_set = 1'b0;
        seamless_clr = 1'b0;
        seam         = v;
        chk(seamless_en, v);
    endtask

    // Leaves in_valid high so that calls run back to back
    task automatic req(input cfs_dir_type d, input logic lin);
        cfs_proj_type p;
        cfs_tap_type  et;
        int           i0, j0, i, j;
        logic         oi, oj, cor;
        p  = exp_proj(d);
        i0 = lin ? (int'(p.s) - 64) >>> 7 : int'(p.s) >> 7;
        j0 = lin ? (int'(p.t) - 64) >>> 7 : int'(p.t) >> 7;
        if (!lin && i0 > 63) i0 = 63;
        if (!lin && j0 > 63) j0 = 63;
        in_valid  = 1'b1;
        in_dir    = d;
        in_linear = lin;
        @(posedge ref_clk);
        #1;
        chk(out_valid, 1'b1);
        chk(out_face, p.face);
        chk({out_s, out_t}, {p.s, p.t});
        chk(out_wrap, !seam ? wrap_texture : lin ? border_texel_clamp : edge_texel_clamp);
        cor = 1'b0;
        for (int g = 0; g < TAP_N; g++) begin
            i  = i0 + g % 2;
            j  = j0 + g / 2;
            oi = i < 0 || i > 63;
            oj = j < 0 || j > 63;
            et = '{1'b1, p.face, 8'(i), 8'(j)};
            if (!lin && g == 0)
                chk(out_taps[g], et);
            else if (!lin)
                chk(out_taps[g].valid, 1'b0);
            else if (!seam || !(oi || oj))
                chk(out_taps[g], et);
            else if (oi && oj) begin
                chk(out_taps[g].valid, 1'b0);
                cor = 1'b1;
            end else
                chk({out_taps[g].valid, out_taps[g].face != p.face}, 2'h3);
        end
        chk(out_corner, cor);
    endtask

    // ------------------------------------------------------------
    // Clock, corner monitor, watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (sys_rst)
            pend <= 1'b0;
        else begin
            chk(corner_out_valid, pend);
            if (pend) chk(corner_out, pend_exp);
            pend     <= corner_valid;
            pend_exp <= mean3(corner_in);
        end
    end

    // About 510 cycles of traffic; a generous margin before calling it a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst      = 1'b1;
        seamless_set = 1'b0;
        seamless_clr = 1'b0;
        in_valid     = 1'b0;
        in_linear    = 1'b0;
        in_dir       = '0;
        ext_req      = 1'b0;
        ext_texels   = '0;
        seam         = 1'b0;
        failures     = 0;
        n_checks     = 0;
        seed         = 32'h0000F10D;
        repeat (16) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        chk({seamless_en, out_valid, out_face, out_wrap}, {1'b0, 1'b0, face_pos_x, wrap_texture});
        set_seam(1'b1, 1'b0, 1'b1);
        set_seam(1'b1, 1'b1, 1'b1);
        set_seam(1'b0, 1'b1, 1'b0);
        for (int sm = 0; sm < 2; sm++) begin
            if (sm == 1) set_seam(1'b1, 1'b0, 1'b1);
            for (int lin = 0; lin < 2; lin++)
                for (int k = 0; k < 9; k++)
                    req(FIX[k], lin[0]);
        end
        req('{16'sh2000, 16'sh2000, 16'sh2000}, 1'b1);
        chk({out_taps[1].face, out_taps[2].face}, {face_pos_y, face_pos_z});
        in_valid = 1'b0;
        @(posedge ref_clk);
        #1;
        chk(out_valid, 1'b0);
        for (int r = 0; r < 4; r++) begin
            set_seam(r[0], !r[0], r[0]);
            for (int k = 0; k < 100; k++)
                req(rnd_dir(), nxt() % 2 == 1);
        end
        in_valid = 1'b0;
        for (int k = 0; k < 40; k++) begin
            w          = nxt();
            ext_req    = 1'b1;
            ext_texels = k < 8 ? {3{w}} : {nxt(), nxt(), nxt()};
            @(posedge ref_clk);
            #1;
        end
        ext_req = 1'b0;
        repeat (4) @(posedge ref_clk);
        give_verdict();
    end
endmodule // tb
